// file: rtl/pmc_pkg.sv
// Power mode and clock manager: shared constants, states and carriers.
// Assumes one 125 MHz core clock and a 32-bit Avalon-MM register port.
package pmc_pkg;
	localparam int        CLK_PERIOD_NS   = 8;
	// Register byte offsets
	localparam logic [3:0] OFS_PWR_CTRL   = 4'h0;
	localparam logic [3:0] OFS_PWR_MODE   = 4'h4;
	localparam logic [3:0] OFS_EXT_FLAG   = 4'h8;
	localparam logic [3:0] OFS_STATUS     = 4'hc;
	// power_control_reg fields
	localparam int        BIT_IDLE        = 0;
	localparam int        BIT_PDOWN       = 1;
	// power_mode_reg fields
	localparam int        BIT_DIV_LO      = 6;
	localparam int        BIT_SWB         = 5;
	localparam int        BIT_AMP_OFF     = 3;
	// ext_int_flag_reg fields
	localparam int        BIT_SRC_SEL     = 3;
	localparam int        BIT_RC_ACTIVE   = 2;
	localparam int        BIT_RC_WAKE     = 1;
	// status register fields
	localparam int        BIT_XTAL_RDY    = 4;
	// Divider encodings and reset value
	localparam logic [1:0] DIV_RSVD       = 2'h0;
	localparam logic [1:0] DIV_4          = 2'h1;
	localparam logic [1:0] DIV_64         = 2'h2;
	localparam logic [1:0] DIV_1024       = 2'h3;
	localparam logic [1:0] DIV_RESET      = DIV_4;
	localparam logic [9:0] CLKS_4         = 10'h004;
	localparam logic [9:0] CLKS_64        = 10'h040;
	localparam logic [9:0] CLKS_1024      = 10'h3ff + 10'h001;
	// Timing
	localparam int        EXT_RST_CLKS    = 8;
	localparam int        RST_HOLD_CLKS   = 8;
	localparam int        WDT_DELAY_CLKS  = 512;
	localparam logic [9:0] EXT_RST_CNT    = 10'(EXT_RST_CLKS);
	localparam logic [9:0] RST_HOLD_CNT   = 10'(RST_HOLD_CLKS);
	localparam logic [9:0] WDT_DELAY_CNT  = 10'(WDT_DELAY_CLKS);

	typedef enum logic [1:0] {
		PMC_RUN   = 2'b00,
		PMC_IDLE  = 2'b01,
		PMC_PDOWN = 2'b11
	} pmc_mode_t;

	typedef struct packed {
		logic rx_start_fall;
		logic rx_enable;
		logic buf_write;
		logic busy;
	} pmc_ser_t;

	typedef struct packed {
		logic [1:0] pin_n;
		logic [1:0] enable;
		logic [1:0] level_mode;
		logic       global_irq_enable;
		logic       ext_ack;
		logic       irq_pending;
	} pmc_irq_t;

	typedef struct packed {
		logic ale;
		logic program_fetch_strobe;
		logic override;
		logic port0_float;
		logic port2_addr;
	} pmc_pins_t;
endpackage

// file: rtl/pmc_top.sv
// Power mode and clock manager: idle, economy divider, switchback,
// clock source choice, power-down and its wake paths.
// Assumes CPU pulses instr_done at each instruction end; all inputs synchronous.
//
// What this block does
// - Idle bit gates CPU clock after instruction
// - Idle holds strobes high, CPU state frozen
// - Enabled interrupt clears idle, runs service
// - Reset pin held eight clocks resets
// - Watchdog runs in idle, resets after 512
// - Divider field selects 4, 64, 1024
// - Peripherals follow divider; idle uses four
// - Divider change waits one instruction
// - Source select applies after one instruction
// - Crystal select refused until crystal ready
// - Switchback forces divide four on triggers
// - Divider writes ignored during busy serial while switchback is on
// - Every reset forces divide by four
// - Power-down stops clocks, strobes low
// - Reset pin wakes power-down at zero
// - Enabled low-level interrupt wakes power-down
// - Wake on RC, then back to crystal
// - Port float and address per mode
//
// Chosen here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pmc_top
	import pmc_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        instr_done,
	input  wire logic        external_reset_pin,
	input  wire logic        wdt_timeout,
	input  wire logic        wdt_restart,
	input  wire logic        wdt_reset_en,
	input  wire logic        xtal_stable,
	input  wire logic        ext_prog_mem,
	input  wire pmc_ser_t    ser,
	input  wire pmc_irq_t    irq,
	output logic             cpu_clk_en,
	output logic             core_tick,
	output logic             periph_tick,
	output logic             sys_reset,
	output logic             wake_irq,
	output logic             xtal_amp_en,
	output logic             clk_src_rc,
	output pmc_pins_t        pins
);
	logic [1:0] rst_sync_r;
	logic       rstn;
	pmc_mode_t  mode_r;
	logic       idle_bit_r, pd_bit_r;
	logic [1:0] div_cur_r, div_pend_r;
	logic       div_pend_v_r, swb_r, amp_off_r;
	logic       src_sel_r, src_apply_r, rc_wake_sel_r, wake_rc_r, xtal_rdy_r;
	logic [9:0] div_cnt_r, ext_cnt_r, hold_cnt_r, wdt_cnt_r;
	logic       wdt_flag_r, wdt_rst_r, ack_r, wake_irq_r;
	logic       wr_en, swb_hit, irq_wake_pd, ext_rst_seen, mc_tick, rc_active;
	logic [9:0] limit;
	logic [7:0] rd_mux;
	function automatic logic [9:0] div_clks(input logic [1:0] sel);
		unique case (sel)
			DIV_64:   div_clks = CLKS_64;
			DIV_1024: div_clks = CLKS_1024;
			default:  div_clks = CLKS_4;
		endcase
	endfunction
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rstn = rst_sync_r[1];
	// One wait state per access; write lands on the edge waitrequest is low
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign wr_en           = avs_write & ack_r;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (avs_read | avs_write) & ~ack_r;
		end
	end
	assign rc_active = ~src_apply_r | wake_rc_r;
	always_comb begin
		rd_mux = 8'h00;
		unique case (avs_address)
			OFS_PWR_CTRL: begin
				rd_mux[BIT_IDLE]  = idle_bit_r;
				rd_mux[BIT_PDOWN] = pd_bit_r;
			end
			OFS_PWR_MODE: begin
				rd_mux[BIT_DIV_LO +: 2] = div_cur_r;
				rd_mux[BIT_SWB]         = swb_r;
				rd_mux[BIT_AMP_OFF]     = amp_off_r;
			end
			OFS_EXT_FLAG: begin
				rd_mux[BIT_SRC_SEL]   = src_sel_r;
				rd_mux[BIT_RC_ACTIVE] = rc_active;
				rd_mux[BIT_RC_WAKE]   = rc_wake_sel_r;
			end
			OFS_STATUS: rd_mux[BIT_XTAL_RDY] = xtal_rdy_r;
			default: rd_mux = 8'h00;
		endcase
	end
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			avs_readdata <= 32'h0;
		end else if (avs_read & ~ack_r) begin
			avs_readdata <= {24'h0, rd_mux};
		end
	end
	assign ext_rst_seen = ext_cnt_r >= EXT_RST_CNT;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ext_cnt_r  <= 10'h0;
			hold_cnt_r <= 10'h0;
		end else begin
			if (!external_reset_pin)
				ext_cnt_r <= 10'h0;
			else if (!ext_rst_seen)
				ext_cnt_r <= ext_cnt_r + 10'h1;
			// Reset stays on two machine cycles after the pin or watchdog lets go
			if (ext_rst_seen || wdt_rst_r)
				hold_cnt_r <= RST_HOLD_CNT;
			else if (hold_cnt_r != 10'h0)
				hold_cnt_r <= hold_cnt_r - 10'h1;
		end
	end
	assign sys_reset = ext_rst_seen | wdt_rst_r | (hold_cnt_r != 10'h0);
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wdt_flag_r <= 1'b0;
			wdt_cnt_r  <= 10'h0;
			wdt_rst_r  <= 1'b0;
		end else if (mode_r == PMC_PDOWN || sys_reset || wdt_restart) begin
			wdt_flag_r <= 1'b0;
			wdt_cnt_r  <= 10'h0;
			wdt_rst_r  <= 1'b0;
		end else if (wdt_timeout) begin
			wdt_flag_r <= 1'b1;
			wdt_cnt_r  <= 10'h0;
		end else if (wdt_flag_r) begin
			wdt_cnt_r <= wdt_cnt_r + 10'h1;
			if (wdt_reset_en && wdt_cnt_r == WDT_DELAY_CNT - 10'h1) begin
				wdt_rst_r  <= 1'b1;
				wdt_flag_r <= 1'b0;
			end
		end
	end
	assign irq_wake_pd = irq.global_irq_enable &
		|(~irq.pin_n & irq.enable & irq.level_mode);

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mode_r     <= PMC_RUN;
			idle_bit_r <= 1'b0;
			pd_bit_r   <= 1'b0;
			wake_irq_r <= 1'b0;
		end else if (sys_reset) begin
			mode_r     <= PMC_RUN;
			idle_bit_r <= 1'b0;
			pd_bit_r   <= 1'b0;
			wake_irq_r <= 1'b0;
		end else begin
			wake_irq_r <= 1'b0;
			unique case (mode_r)
				PMC_RUN: begin
					if (wr_en && avs_address == OFS_PWR_CTRL) begin
						idle_bit_r <= avs_writedata[BIT_IDLE];
						pd_bit_r   <= avs_writedata[BIT_PDOWN];
					end else if (instr_done && pd_bit_r) begin
						mode_r <= PMC_PDOWN;
					end else if (instr_done && idle_bit_r) begin
						mode_r <= PMC_IDLE;
					end
				end
				PMC_IDLE: begin
					if (irq.irq_pending) begin
						idle_bit_r <= 1'b0;
						mode_r     <= PMC_RUN;
						wake_irq_r <= 1'b1;
					end
				end
				PMC_PDOWN: begin
					if (irq_wake_pd) begin
						pd_bit_r   <= 1'b0;
						idle_bit_r <= 1'b0;
						mode_r     <= PMC_RUN;
						wake_irq_r <= 1'b1;
					end
				end
				default: mode_r <= PMC_RUN;
			endcase
		end
	end
	assign wake_irq = wake_irq_r;
	assign swb_hit = swb_r & ((ser.rx_start_fall & ser.rx_enable) | ser.buf_write | irq.ext_ack);

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			div_cur_r    <= DIV_RESET;
			div_pend_r   <= DIV_RESET;
			div_pend_v_r <= 1'b0;
			swb_r        <= 1'b0;
			amp_off_r    <= 1'b0;
		end else if (sys_reset) begin
			div_cur_r    <= DIV_RESET;
			div_pend_r   <= DIV_RESET;
			div_pend_v_r <= 1'b0;
			swb_r        <= 1'b0;
			amp_off_r    <= 1'b0;
		end else begin
			if (swb_hit) begin
				div_cur_r    <= DIV_4;
				div_pend_v_r <= 1'b0;
			end else if (div_pend_v_r && instr_done) begin
				div_cur_r    <= div_pend_r;
				div_pend_v_r <= 1'b0;
			end
			if (wr_en && avs_address == OFS_PWR_MODE) begin
				swb_r <= avs_writedata[BIT_SWB];
				// amplifier off only while on RC
				if (rc_active)
					amp_off_r <= avs_writedata[BIT_AMP_OFF];
				// ignore during serial activity while switchback is on; reserved code ignored
				if (!(swb_r && ser.busy) && !swb_hit &&
				    avs_writedata[BIT_DIV_LO +: 2] != DIV_RSVD) begin
					div_pend_r   <= avs_writedata[BIT_DIV_LO +: 2];
					div_pend_v_r <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			src_sel_r     <= 1'b1;
			src_apply_r   <= 1'b1;
			rc_wake_sel_r <= 1'b0;
			wake_rc_r     <= 1'b0;
			xtal_rdy_r    <= 1'b0;
		end else begin
			xtal_rdy_r <= xtal_stable & ~amp_off_r & (mode_r != PMC_PDOWN);
			if (sys_reset) begin
				src_sel_r     <= 1'b1;
				src_apply_r   <= 1'b1;
				rc_wake_sel_r <= 1'b0;
			end else begin
				if (wr_en && avs_address == OFS_EXT_FLAG) begin
					rc_wake_sel_r <= avs_writedata[BIT_RC_WAKE];
					if (!avs_writedata[BIT_SRC_SEL] || xtal_rdy_r)
						src_sel_r <= avs_writedata[BIT_SRC_SEL];
				end
				if (instr_done)
					src_apply_r <= src_sel_r;
			end
			// run on RC until the crystal settles
			if (mode_r == PMC_PDOWN && irq_wake_pd && rc_wake_sel_r && !sys_reset)
				wake_rc_r <= 1'b1;
			else if (xtal_rdy_r)
				wake_rc_r <= 1'b0;
		end
	end
	assign clk_src_rc  = rc_active;
	assign xtal_amp_en = ~amp_off_r & (mode_r != PMC_PDOWN);
	assign limit   = (mode_r == PMC_IDLE) ? CLKS_4 - 10'h1 : div_clks(div_cur_r) - 10'h1;
	assign mc_tick = div_cnt_r >= limit;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			div_cnt_r <= 10'h0;
		end else if (mc_tick || mode_r == PMC_PDOWN) begin
			div_cnt_r <= 10'h0;
		end else begin
			div_cnt_r <= div_cnt_r + 10'h1;
		end
	end
	assign cpu_clk_en  = (mode_r == PMC_RUN) & ~sys_reset;
	assign core_tick   = mc_tick & cpu_clk_en;
	assign periph_tick = mc_tick & (mode_r != PMC_PDOWN);
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pins <= '0;
		end else begin
			pins.override             <= mode_r != PMC_RUN;
			pins.ale                  <= mode_r == PMC_IDLE;
			pins.program_fetch_strobe <= mode_r == PMC_IDLE;
			pins.port0_float          <= ext_prog_mem & (mode_r != PMC_RUN);
			pins.port2_addr           <= ext_prog_mem & (mode_r == PMC_IDLE);
		end
	end

	a_idle_gate: assert property (@(posedge core_clk) disable iff (!rstn)
		mode_r == PMC_IDLE |-> !cpu_clk_en && !core_tick)
		else $error("cpu clock runs in idle");
	a_idle_strobe: assert property (@(posedge core_clk) disable iff (!rstn)
		mode_r == PMC_IDLE ##1 mode_r == PMC_IDLE |-> pins.ale && pins.program_fetch_strobe)
		else $error("strobes not high in idle");
	a_idle_wake: assert property (@(posedge core_clk) disable iff (!rstn)
		mode_r == PMC_IDLE && irq.irq_pending && !sys_reset
		|=> mode_r == PMC_RUN && !idle_bit_r && wake_irq)
		else $error("interrupt did not end idle");
	a_ext_reset: assert property (@(posedge core_clk) disable iff (!rstn)
		external_reset_pin [*8] |=> sys_reset)
		else $error("reset pin not recognized");
	a_wdt_delay: assert property (@(posedge core_clk) disable iff (!rstn)
		wdt_rst_r && !$past(wdt_rst_r) |-> $past(wdt_cnt_r) == WDT_DELAY_CNT - 10'h1)
		else $error("watchdog reset at wrong count");
	a_div_legal: assert property (@(posedge core_clk) disable iff (!rstn)
		div_cur_r != DIV_RSVD)
		else $error("reserved divider active");
	a_idle_rate: assert property (@(posedge core_clk) disable iff (!rstn)
		periph_tick && mode_r == PMC_IDLE ##1 mode_r == PMC_IDLE [*4] |-> periph_tick)
		else $error("idle peripheral rate not four");
	a_xtal_refuse: assert property (@(posedge core_clk) disable iff (!rstn)
		!src_sel_r && !xtal_rdy_r && !sys_reset |=> !src_sel_r)
		else $error("crystal selected while not ready");
	a_switchback: assert property (@(posedge core_clk) disable iff (!rstn)
		swb_hit && !sys_reset |=> div_cur_r == DIV_4)
		else $error("switchback missed");
	a_reset_div: assert property (@(posedge core_clk) disable iff (!rstn)
		sys_reset |=> div_cur_r == DIV_4)
		else $error("reset left slow divider");
	a_pd_stop: assert property (@(posedge core_clk) disable iff (!rstn)
		mode_r == PMC_PDOWN |-> !periph_tick && !cpu_clk_en)
		else $error("clocks running in power-down");
	a_pd_wake: assert property (@(posedge core_clk) disable iff (!rstn)
		mode_r == PMC_PDOWN && irq_wake_pd && !sys_reset |=> !pd_bit_r && mode_r == PMC_RUN)
		else $error("power-down bit kept after wake");

	c_idle_wake: cover property (@(posedge core_clk) disable iff (!rstn)
		mode_r == PMC_IDLE ##1 wake_irq);
	c_pd_wake: cover property (@(posedge core_clk) disable iff (!rstn)
		mode_r == PMC_PDOWN ##1 mode_r == PMC_RUN);
	c_slow_back: cover property (@(posedge core_clk) disable iff (!rstn)
		div_cur_r == DIV_1024 ##1 swb_hit);
	c_rc_wake: cover property (@(posedge core_clk) disable iff (!rstn)
		wake_rc_r ##1 !wake_rc_r);
endmodule
`default_nettype wire

// file: tb/pmc_far_model.sv
// Far-side stand-in: a CPU that ends one instruction per machine cycle
// and a crystal that needs a warm-up once its amplifier is on.
// Assumes it sees the manager's core_tick, cpu_clk_en and xtal_amp_en.
`timescale 1ns/1ps
`default_nettype none
module pmc_far_model
	import pmc_pkg::*;
#(
	parameter int WARM_CLKS = 20
) (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic core_tick,
	input  wire logic cpu_clk_en,
	input  wire logic xtal_amp_en,
	output logic      instr_done,
	output logic      xtal_stable
);
	int warm_r;

	// Short instructions keep every switch latency small
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			instr_done <= 1'b0;
		else
			instr_done <= core_tick & cpu_clk_en;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			warm_r <= 0;
		else if (!xtal_amp_en)
			warm_r <= 0;
		else if (warm_r < WARM_CLKS)
			warm_r <= warm_r + 1;
	end
	assign xtal_stable = (warm_r == WARM_CLKS);
endmodule
`default_nettype wire

// file: tb/tb_power_mode_clock_manager.sv
// Self-checking bench for the power mode and clock manager.
// Assumes pmc_pkg, pmc_top and pmc_far_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_power_mode_clock_manager;
	import pmc_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst_n, avs_read, avs_write, external_reset_pin, ext_prog_mem;
	logic        avs_waitrequest, cpu_clk_en, core_tick, periph_tick, sys_reset;
	logic        wake_irq, xtal_amp_en, clk_src_rc, instr_done, xtal_stable;
	logic        wdt_timeout, wdt_restart, wdt_reset_en;
	logic [3:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [7:0]  q;
	pmc_ser_t    ser;
	pmc_irq_t    irq;
	pmc_pins_t   pins;
	int          n_fail = 0;
	int          checks_done = 0;

	always #4 core_clk = ~core_clk;

	pmc_top DUT (
		.core_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .instr_done, .external_reset_pin,
		.wdt_timeout, .wdt_restart, .wdt_reset_en,
		.xtal_stable, .ext_prog_mem, .ser, .irq, .cpu_clk_en, .core_tick,
		.periph_tick, .sys_reset, .wake_irq, .xtal_amp_en, .clk_src_rc, .pins
	);

	pmc_far_model far (
		.core_clk, .rst_n, .core_tick, .cpu_clk_en, .xtal_amp_en,
		.instr_done, .xtal_stable
	);

	task automatic report_and_stop();
		if (n_fail == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask

	function automatic logic pick(input int s);
		logic [5:0] v;
		v = {periph_tick, core_tick, clk_src_rc, sys_reset, wake_irq, cpu_clk_en};
		return v[s];
	endfunction

	// Outputs are looked at on the falling edge, where they have settled
	task automatic wt(input int s, input logic v, input int lim);
		for (int k = 0; k < lim; k++) begin
			@(negedge core_clk);
			if (pick(s) === v)
				return;
		end
		chk("bounded wait", 32'(v), 32'(pick(s)));
		report_and_stop();
	endtask

	task automatic gap(input int s, input int e);
		int g;
		wt(s, 1'b1, 3000);
		for (g = 1; g < 3000; g++) begin
			@(negedge core_clk);
			if (pick(s) === 1'b1)
				break;
		end
		if (g == 3000) begin
			chk("tick gap", 32'h0, 32'(g));
			report_and_stop();
		end
		if (e != 0)
			chk("tick gap", 32'(e), 32'(g));
	endtask

	// Request held until waitrequest is seen low, released at that edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
		output logic [7:0] r);
		int k;
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {24'h0, d};
		for (k = 0; k < 50; k++) begin
			@(posedge core_clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		if (k == 50) begin
			chk("waitrequest", 32'h0, 32'h1);
			report_and_stop();
		end
		r = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	function automatic logic [7:0] power_mode_reg(input logic [1:0] cd, input logic sw, input logic am);
		return {cd, sw, 1'b0, am, 3'b000};
	endfunction

	task automatic t_regs();
		bus(1'b0, OFS_PWR_MODE, 8'h00, q);
		chk("div reset", 32'(DIV_4), 32'(q[7:6]));
		bus(1'b0, OFS_PWR_CTRL, 8'h00, q);
		chk("ctrl reset", 32'h0, 32'(q[1:0]));
		bus(1'b1, 4'h2, 8'hff, q);
		bus(1'b0, 4'h2, 8'h00, q);
		chk("unmapped", 32'h0, 32'(q));
	endtask

	task automatic t_div();
		logic [1:0] cd [4] = '{DIV_64, DIV_4, DIV_1024, DIV_4};
		int         nc [4] = '{64, 4, 1024, 4};
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, OFS_PWR_MODE, power_mode_reg(cd[i], 1'b0, 1'b0), q);
			gap(4, 0);
			gap(4, nc[i]);
			gap(5, nc[i]);
		end
		bus(1'b1, OFS_PWR_MODE, power_mode_reg(DIV_64, 1'b0, 1'b0), q);
		gap(4, 0);
		bus(1'b1, OFS_PWR_MODE, power_mode_reg(DIV_RSVD, 1'b0, 1'b0), q);
		gap(4, 0);
		gap(4, 64);
	endtask

	task automatic t_idle();
		@(posedge core_clk);
		ext_prog_mem <= 1'b1;
		bus(1'b1, OFS_PWR_MODE, power_mode_reg(DIV_64, 1'b0, 1'b0), q);
		gap(4, 0);
		bus(1'b1, OFS_PWR_CTRL, 8'h01, q);
		wt(0, 1'b0, 200);
		// Pin states are registered one edge after the mode
		@(negedge core_clk);
		chk("idle pins", 32'h1f, 32'(pins));
		gap(5, 4);
		@(posedge core_clk);
		irq.irq_pending <= 1'b1;
		wt(1, 1'b1, 20);
		chk("cpu run", 32'h1, 32'(cpu_clk_en));
		@(posedge core_clk);
		irq.irq_pending <= 1'b0;
		bus(1'b0, OFS_PWR_CTRL, 8'h00, q);
		chk("idle bit", 32'h0, 32'(q[BIT_IDLE]));
	endtask

	task automatic t_pd(input logic ext, input logic [4:0] ep);
		@(posedge core_clk);
		ext_prog_mem <= ext;
		bus(1'b1, OFS_PWR_MODE, power_mode_reg(DIV_64, 1'b0, 1'b0), q);
		gap(4, 0);
		if (ext)
			bus(1'b1, OFS_EXT_FLAG, 8'h0a, q);
		bus(1'b1, OFS_PWR_CTRL, 8'h02, q);
		wt(0, 1'b0, 200);
		@(negedge core_clk);
		chk("pd pins", 32'(ep), 32'(pins));
		@(posedge core_clk);
		if (ext) begin
			irq.pin_n <= 2'b10;
			irq.enable <= 2'b01;
			irq.global_irq_enable <= 1'b1;
			repeat (10) @(negedge core_clk);
			chk("edge mode wake", 32'h0, 32'(cpu_clk_en));
			@(posedge core_clk);
			irq.level_mode <= 2'b01;
			wt(1, 1'b1, 20);
			chk("rc wake", 32'h1, 32'(clk_src_rc));
			wt(3, 1'b0, 50);
		end else begin
			external_reset_pin <= 1'b1;
			repeat (4) @(negedge core_clk);
			chk("early reset", 32'h0, 32'(sys_reset));
			wt(2, 1'b1, 10);
			@(posedge core_clk);
			external_reset_pin <= 1'b0;
			wt(2, 1'b0, 30);
		end
		chk("cpu run", 32'h1, 32'(cpu_clk_en));
		@(posedge core_clk);
		irq <= '{pin_n: 2'b11, default: '0};
		bus(1'b0, OFS_PWR_CTRL, 8'h00, q);
		chk("pd bit", 32'h0, 32'(q[BIT_PDOWN]));
		bus(1'b0, OFS_PWR_MODE, 8'h00, q);
		chk("div after wake", 32'(ext ? DIV_64 : DIV_4), 32'(q[7:6]));
	endtask

	task automatic t_swb();
		pmc_ser_t trg [3] = '{4'b1100, 4'b0010, 4'b0000};
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, OFS_PWR_MODE, power_mode_reg(DIV_64, 1'b1, 1'b0), q);
			gap(4, 0);
			gap(4, 64);
			@(posedge core_clk);
			ser <= trg[i];
			irq.ext_ack <= (i == 2);
			@(posedge core_clk);
			ser <= '0;
			irq.ext_ack <= 1'b0;
			gap(4, 0);
			gap(4, 4);
		end
		@(posedge core_clk);
		ser.busy <= 1'b1;
		bus(1'b1, OFS_PWR_MODE, power_mode_reg(DIV_64, 1'b1, 1'b0), q);
		// Let an instruction end so an accepted write would have applied
		gap(4, 0);
		bus(1'b0, OFS_PWR_MODE, 8'h00, q);
		ser.busy <= 1'b0;
		chk("div while busy", 32'(DIV_4), 32'(q[7:6]));
	endtask

	task automatic t_wdt();
		int n;
		bus(1'b1, OFS_PWR_MODE, power_mode_reg(DIV_64, 1'b0, 1'b0), q);
		@(posedge core_clk);
		wdt_reset_en <= 1'b1;
		wdt_timeout <= 1'b1;
		@(posedge core_clk);
		wdt_timeout <= 1'b0;
		wdt_restart <= 1'b1;
		@(posedge core_clk);
		wdt_restart <= 1'b0;
		repeat (WDT_DELAY_CLKS + 4) @(negedge core_clk);
		chk("restarted wdt", 32'h0, 32'(sys_reset));
		@(posedge core_clk);
		wdt_timeout <= 1'b1;
		@(posedge core_clk);
		wdt_timeout <= 1'b0;
		for (n = 1; n < 600; n++) begin
			@(negedge core_clk);
			if (sys_reset === 1'b1)
				break;
		end
		chk("wdt delay", 32'(WDT_DELAY_CLKS + 1), 32'(n));
		wt(2, 1'b0, 30);
		bus(1'b0, OFS_PWR_MODE, 8'h00, q);
		chk("div after wdt", 32'(DIV_4), 32'(q[7:6]));
	endtask

	task automatic t_src();
		bus(1'b1, OFS_EXT_FLAG, 8'h00, q);
		wt(3, 1'b1, 50);
		bus(1'b0, OFS_EXT_FLAG, 8'h00, q);
		chk("rc active", 32'h1, 32'(q[BIT_RC_ACTIVE]));
		bus(1'b1, OFS_PWR_MODE, power_mode_reg(DIV_4, 1'b0, 1'b1), q);
		@(negedge core_clk);
		chk("amp enable", 32'h0, 32'(xtal_amp_en));
		bus(1'b0, OFS_STATUS, 8'h00, q);
		chk("crystal ready", 32'h0, 32'(q[BIT_XTAL_RDY]));
		bus(1'b1, OFS_EXT_FLAG, 8'h08, q);
		bus(1'b0, OFS_EXT_FLAG, 8'h00, q);
		chk("refused select", 32'h0, 32'(q[BIT_SRC_SEL]));
		bus(1'b1, OFS_PWR_MODE, power_mode_reg(DIV_4, 1'b0, 1'b0), q);
		// Warm-up length is fixed by the far-side model
		repeat (30) @(posedge core_clk);
		bus(1'b1, OFS_EXT_FLAG, 8'h08, q);
		wt(3, 1'b0, 50);
	endtask

	initial begin
		rst_n = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		external_reset_pin = 1'b0;
		wdt_timeout = 1'b0;
		wdt_restart = 1'b0;
		wdt_reset_en = 1'b0;
		ext_prog_mem = 1'b0;
		ser = '0;
		irq = '{pin_n: 2'b11, default: '0};
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		t_regs();
		t_div();
		t_idle();
		t_pd(1'b0, 5'h04);
		t_pd(1'b1, 5'h06);
		t_swb();
		t_wdt();
		t_src();
		report_and_stop();
	end
endmodule
`default_nettype wire
